//--- fbc_core.sv
// four-bit instruction execution core: registers, skip, stack
// assumes a decoded opcode stream with instr_valid, RAM nibble and peripheral inputs
// How it works
// - a met skip cancels the next instruction in place; PC advances by one
// - skipped instruction keeps its cycles, except table call and returns take one
// - program counter is 14 bits, 7-bit page over 7-bit offset
// - eight 14-bit stack entries, 3-bit pointer, pre-increment push, post-decrement pop
// - data pointer is bank, file, digit registers, 2+4+4 bits
// - skip when accumulator equals 4-bit immediate
// - set memory bit j to one, other bits kept
// - skip when memory bit j is zero
// - external request test skips and clears flag only when its enable is zero
// - first timer request test skips and clears only when enable is zero
// - second timer request test skips and clears only when enable is zero
// - pin level test skips on high if select is one, else on low
// - pair load writes B high and A low into reload and counter
// - reload-only load writes B and A into first reload only
// - converter read picks bits 9..2 or 7..0 by mode bit
// - aux port read puts pin in bit 0, clears bits 3..1
`timescale 1ns/10ps
`include "fbc_params.svh"
module fbc_core
  import fbc_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    instr_valid,
  input  wire fbc_op_t                 instr_op,
  input  wire logic [3:0]              instr_imm,
  input  wire logic [1:0]              instr_bit,
  input  wire logic [`FBC_PAGE_W-1:0]  instr_page,
  input  wire logic [`FBC_PAGE_W-1:0]  instr_offset,
  input  wire logic [7:0]              rom_data,
  input  wire logic [3:0]              mem_rdata,
  input  wire logic [9:0]              conversion_result,
  input  wire logic                    converter_mode_bit,
  input  wire logic                    aux_port_pin,
  input  wire logic [1:0]              port_two_pins,
  input  wire logic                    interrupt_pin,
  input  wire logic                    pin_level_select_bit,
  input  wire logic                    ext_irq_enable_bit,
  input  wire logic                    first_timer_irq_enable_bit,
  input  wire logic                    second_timer_irq_enable_bit,
  input  wire logic                    external_request_flag,
  input  wire logic                    first_timer_request_flag,
  input  wire logic                    second_timer_request_flag,
  output logic [`FBC_PC_W-1:0]         program_counter,
  output logic [`FBC_DP_W-1:0]         data_address_pointer,
  output logic                         mem_we,
  output logic [3:0]                   mem_wdata,
  output logic [3:0]                   acc,
  output logic [3:0]                   breg,
  output logic                         carry_flag,
  output logic [`FBC_SP_W-1:0]         stack_pointer,
  output logic                         skip_pending,
  output logic                         busy,
  output logic                         clear_external_request,
  output logic                         clear_first_timer_request,
  output logic                         clear_second_timer_request,
  output logic                         first_timer_reload_we,
  output logic                         first_timer_count_we,
  output logic                         second_timer_reload_we,
  output logic                         second_timer_count_we,
  output logic [7:0]                   timer_load_data
);
  ////////////////////////////////////////////////////////////////////////////
  logic [`FBC_PAGE_W-1:0] program_page_part_reg, program_page_part_next;
  logic [`FBC_PAGE_W-1:0] page_offset_part_reg, page_offset_part_next;
  logic [`FBC_SP_W-1:0]   sp_reg, sp_next;
  logic [1:0]             bank_reg, bank_next;
  logic [3:0]             file_reg, file_next;
  logic [3:0]             digit_reg, digit_next;
  logic [3:0]             acc_reg, acc_next;
  logic [3:0]             b_reg, b_next;
  logic                   cy_reg, cy_next;
  logic                   skip_reg, skip_next;
  fbc_state_t             state_reg, state_next;
  fbc_op_t                op2_reg;
  logic [`FBC_PC_W-1:0]   ret_pc;
  logic [`FBC_PC_W-1:0]   ret_hold_reg;
  logic                   pin_sync;
  logic                   int_pin_sync;
  logic [1:0]             p2_sync;
  logic                   stk_we;
  logic [`FBC_SP_W-1:0]   stk_waddr;
  logic [`FBC_PC_W-1:0]   stk_wdata;

  function automatic logic [4:0] fbc_add(input logic [3:0] a, input logic [3:0] m, input logic c);
    fbc_add = {1'b0, a} + {1'b0, m} + {4'h0, c};
  endfunction

  function automatic logic [`FBC_PC_W-1:0] fbc_inc_pc(input logic [`FBC_PC_W-1:0] pc);
    fbc_inc_pc = pc + `FBC_PC_W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  fbc_sync u_sync_aux (.mclk(mclk), .reset(reset), .din(aux_port_pin),     .dout(pin_sync));
  fbc_sync u_sync_int (.mclk(mclk), .reset(reset), .din(interrupt_pin),    .dout(int_pin_sync));
  fbc_sync u_sync_p20 (.mclk(mclk), .reset(reset), .din(port_two_pins[0]), .dout(p2_sync[0]));
  fbc_sync u_sync_p21 (.mclk(mclk), .reset(reset), .din(port_two_pins[1]), .dout(p2_sync[1]));

  fbc_stack u_stack (
    .mclk    (mclk),
    .wr_en   (stk_we),
    .wr_addr (stk_waddr),
    .wr_data (stk_wdata),
    .rd_addr (sp_reg),
    .rd_data (ret_pc)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire [`FBC_PC_W-1:0] pc_cur   = {program_page_part_reg, page_offset_part_reg};
  wire [`FBC_PC_W-1:0] pc_inc   = fbc_inc_pc(pc_cur);
  wire                 exec     = instr_valid && (state_reg == FBC_ST_FETCH);
  wire                 live     = exec && !skip_reg;
  wire                 killed   = exec && skip_reg;
  wire [4:0]           amc_sum  = fbc_add(acc_reg, mem_rdata, cy_reg);
  wire                 bit_val  = mem_rdata[instr_bit];
  wire [3:0]           bit_mask = 4'h1 << instr_bit;
  wire                 two_cyc  = (instr_op == FBC_OP_TABCALL) || (instr_op == FBC_OP_RET)
                                  || (instr_op == FBC_OP_RETSKIP);
  wire                 ext_hit  = !ext_irq_enable_bit && external_request_flag;
  wire                 t1_hit   = !first_timer_irq_enable_bit && first_timer_request_flag;
  wire                 t2_hit   = !second_timer_irq_enable_bit && second_timer_request_flag;
  wire                 pin_hit  = (int_pin_sync == pin_level_select_bit);
  wire                 cmp_mode = (converter_mode_bit == `FBC_CMP_MODE);
  wire [7:0]           adc_sel  = cmp_mode ? conversion_result[7:0] : conversion_result[9:2];
  wire                 push     = live && ((instr_op == FBC_OP_CALL) || (instr_op == FBC_OP_TABCALL));
  wire [`FBC_SP_W-1:0] sp_inc   = sp_reg + `FBC_SP_W'(1);

  assign stk_we    = push;
  assign stk_waddr = sp_inc;
  assign stk_wdata = pc_inc;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    program_page_part_next = program_page_part_reg;
    page_offset_part_next  = page_offset_part_reg;
    sp_next    = sp_reg;
    bank_next  = bank_reg;
    file_next  = file_reg;
    digit_next = digit_reg;
    acc_next   = acc_reg;
    b_next     = b_reg;
    cy_next    = cy_reg;
    skip_next  = skip_reg;
    state_next = state_reg;
    if (killed) begin
      skip_next = 1'b0;
      {program_page_part_next, page_offset_part_next} = pc_inc;
      state_next = FBC_ST_FETCH;
    end else if (live) begin
      skip_next = 1'b0;
      {program_page_part_next, page_offset_part_next} = pc_inc;
      unique case (instr_op)
        FBC_OP_AMC: begin
          acc_next = amc_sum[3:0];
          cy_next  = amc_sum[4];
        end
        FBC_OP_SEA:     skip_next = (acc_reg == instr_imm);
        FBC_OP_SKIPCLR: skip_next = !bit_val;
        FBC_OP_TEXT:    skip_next = ext_hit;
        FBC_OP_TT1:     skip_next = t1_hit;
        FBC_OP_TT2:     skip_next = t2_hit;
        FBC_OP_TPIN:    skip_next = pin_hit;
        FBC_OP_RDADC: begin
          b_next   = adc_sel[7:4];
          acc_next = adc_sel[3:0];
        end
        FBC_OP_RDAUX: acc_next = {3'h0, pin_sync};
        FBC_OP_RDP2:  acc_next = {2'h0, p2_sync};
        FBC_OP_TAB:   acc_next = b_reg;
        FBC_OP_TBA:   b_next = acc_reg;
        FBC_OP_LXY: begin
          file_next  = instr_imm;
          digit_next = {2'h0, instr_bit};
        end
        FBC_OP_LZ: bank_next = instr_bit;
        FBC_OP_BRANCH: begin
          program_page_part_next = instr_page;
          page_offset_part_next  = instr_offset;
        end
        FBC_OP_CALL: begin
          sp_next = sp_inc;
          program_page_part_next = instr_page;
          page_offset_part_next  = instr_offset;
        end
        FBC_OP_TABCALL: begin
          sp_next = sp_inc;
          program_page_part_next = instr_page;
          page_offset_part_next  = {digit_reg[2:0], acc_reg};
          state_next = FBC_ST_EXEC2;
        end
        FBC_OP_RET, FBC_OP_RETSKIP: begin
          state_next = FBC_ST_EXEC2;
          skip_next  = 1'b0;
        end
        default: ;
      endcase
    end else if (state_reg == FBC_ST_EXEC2) begin
      state_next = FBC_ST_FETCH;
      unique case (op2_reg)
        FBC_OP_TABCALL: begin
          b_next   = rom_data[7:4];
          acc_next = rom_data[3:0];
          {program_page_part_next, page_offset_part_next} = ret_hold_reg;
          sp_next = sp_reg - `FBC_SP_W'(1);
        end
        FBC_OP_RET, FBC_OP_RETSKIP: begin
          {program_page_part_next, page_offset_part_next} = ret_pc;
          sp_next   = sp_reg - `FBC_SP_W'(1);
          skip_next = (op2_reg == FBC_OP_RETSKIP);
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (reset) begin
      program_page_part_reg <= `FBC_PAGE_W'(`FBC_PC_RST >> `FBC_PAGE_W);
      page_offset_part_reg  <= `FBC_PAGE_W'(`FBC_PC_RST);
      sp_reg    <= `FBC_SP_RST;
      bank_reg  <= '0;
      file_reg  <= `FBC_NIB_ZERO;
      digit_reg <= `FBC_NIB_ZERO;
      acc_reg   <= `FBC_NIB_ZERO;
      b_reg     <= `FBC_NIB_ZERO;
      cy_reg    <= 1'b0;
      skip_reg  <= 1'b0;
      state_reg <= FBC_ST_FETCH;
      op2_reg   <= FBC_OP_NOP;
      ret_hold_reg <= `FBC_PC_RST;
    end else begin
      program_page_part_reg <= program_page_part_next;
      page_offset_part_reg  <= page_offset_part_next;
      sp_reg    <= sp_next;
      bank_reg  <= bank_next;
      file_reg  <= file_next;
      digit_reg <= digit_next;
      acc_reg   <= acc_next;
      b_reg     <= b_next;
      cy_reg    <= cy_next;
      skip_reg  <= skip_next;
      state_reg <= state_next;
      op2_reg   <= (live || killed) ? (killed ? FBC_OP_NOP : instr_op) : op2_reg;
      ret_hold_reg <= pc_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_we <= 1'b0;
      mem_wdata <= `FBC_NIB_ZERO;
      clear_external_request <= 1'b0;
      clear_first_timer_request <= 1'b0;
      clear_second_timer_request <= 1'b0;
      first_timer_reload_we <= 1'b0;
      first_timer_count_we <= 1'b0;
      second_timer_reload_we <= 1'b0;
      second_timer_count_we <= 1'b0;
      timer_load_data <= 8'h00;
    end else begin
      mem_we    <= live && (instr_op == FBC_OP_SETBIT);
      mem_wdata <= mem_rdata | bit_mask;
      clear_external_request <= live && (instr_op == FBC_OP_TEXT) && ext_hit;
      clear_first_timer_request <= live && (instr_op == FBC_OP_TT1) && t1_hit;
      clear_second_timer_request <= live && (instr_op == FBC_OP_TT2) && t2_hit;
      first_timer_reload_we <= live && ((instr_op == FBC_OP_LT1PAIR)
                               || (instr_op == FBC_OP_LT1RELOAD));
      first_timer_count_we <= live && (instr_op == FBC_OP_LT1PAIR);
      second_timer_reload_we <= live && (instr_op == FBC_OP_LT2PAIR);
      second_timer_count_we <= live && (instr_op == FBC_OP_LT2PAIR);
      timer_load_data <= {b_reg, acc_reg};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      program_counter <= `FBC_PC_RST;
      data_address_pointer <= '0;
      acc <= `FBC_NIB_ZERO;
      breg <= `FBC_NIB_ZERO;
      carry_flag <= 1'b0;
      stack_pointer <= `FBC_SP_RST;
      skip_pending <= 1'b0;
      busy <= 1'b0;
    end else begin
      program_counter <= {program_page_part_next, page_offset_part_next};
      data_address_pointer <= {bank_next, file_next, digit_next};
      acc <= acc_next;
      breg <= b_next;
      carry_flag <= cy_next;
      stack_pointer <= sp_next;
      skip_pending <= skip_next;
      busy <= (state_next == FBC_ST_EXEC2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_skip_holds_pc_step;
    @(posedge mclk) disable iff (reset) killed |=> (program_counter == $past(pc_inc));
  endproperty
  a_skip_holds_pc_step: assert property (p_skip_holds_pc_step) else $error("skip moved pc wrongly");

  property p_skip_short_ret;
    @(posedge mclk) disable iff (reset)
      (killed && two_cyc) |=> (!busy && !skip_pending && (stack_pointer == $past(sp_reg)));
  endproperty
  a_skip_short_ret: assert property (p_skip_short_ret) else $error("skipped return not one cycle");

  property p_skip_long_other;
    @(posedge mclk) disable iff (reset) (killed && !two_cyc) |=> !busy;
  endproperty
  a_skip_long_other: assert property (p_skip_long_other) else $error("skipped op took extra cycle");

  property p_amc;
    @(posedge mclk) disable iff (reset)
      (live && instr_op == FBC_OP_AMC) |=>
        ({carry_flag, acc} == (5'($past(acc_reg)) + 5'($past(mem_rdata)) + 5'($past(cy_reg))));
  endproperty
  a_amc: assert property (p_amc) else $error("add with carry wrong");

  property p_sea;
    @(posedge mclk) disable iff (reset)
      (live && instr_op == FBC_OP_SEA) |=> (skip_pending == ($past(acc_reg) == $past(instr_imm)));
  endproperty
  a_sea: assert property (p_sea) else $error("compare skip wrong");

  property p_ext_clear;
    @(posedge mclk) disable iff (reset) clear_external_request |-> skip_pending;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("flag cleared without skip");

  property p_reload_only;
    @(posedge mclk) disable iff (reset)
      (live && instr_op == FBC_OP_LT1RELOAD) |=> (first_timer_reload_we && !first_timer_count_we);
  endproperty
  a_reload_only: assert property (p_reload_only) else $error("reload-only touched counter");

  property p_aux;
    @(posedge mclk) disable iff (reset) (live && instr_op == FBC_OP_RDAUX) |=> (acc[3:1] == 3'h0);
  endproperty
  a_aux: assert property (p_aux) else $error("aux read upper bits set");

  property p_port2;
    @(posedge mclk) disable iff (reset) (live && instr_op == FBC_OP_RDP2) |=> (acc[3:2] == 2'h0);
  endproperty
  a_port2: assert property (p_port2) else $error("port two read upper bits set");
endmodule

//--- fbc_params.svh
// constants for the four-bit instruction core
// assumes inclusion by every file of the core
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH
`define FBC_PC_W       14
`define FBC_PAGE_W     7
`define FBC_SP_W       3
`define FBC_STK_DEPTH  8
`define FBC_DP_W       10
`define FBC_PC_RST     14'h0000
`define FBC_SP_RST     3'h7
`define FBC_NIB_ZERO   4'h0
`define FBC_CMP_MODE   1'b1
`endif

//--- fbc_pkg.sv
// types for the four-bit instruction core
// assumes fbc_params.svh holds the numeric constants
`include "fbc_params.svh"
package fbc_pkg;
  typedef enum logic [4:0] {
    FBC_OP_NOP        = 5'h00,
    FBC_OP_AMC        = 5'h01,
    FBC_OP_SEA        = 5'h02,
    FBC_OP_SETBIT     = 5'h03,
    FBC_OP_SKIPCLR    = 5'h04,
    FBC_OP_TEXT       = 5'h05,
    FBC_OP_TT1        = 5'h06,
    FBC_OP_TT2        = 5'h07,
    FBC_OP_TPIN       = 5'h08,
    FBC_OP_LT1PAIR    = 5'h09,
    FBC_OP_LT2PAIR    = 5'h0A,
    FBC_OP_LT1RELOAD  = 5'h0B,
    FBC_OP_RDADC      = 5'h0C,
    FBC_OP_RDAUX      = 5'h0D,
    FBC_OP_RDP2       = 5'h0E,
    FBC_OP_BRANCH     = 5'h0F,
    FBC_OP_CALL       = 5'h10,
    FBC_OP_RET        = 5'h11,
    FBC_OP_RETSKIP    = 5'h12,
    FBC_OP_TABCALL    = 5'h13,
    FBC_OP_TAB        = 5'h14,
    FBC_OP_TBA        = 5'h15,
    FBC_OP_LXY        = 5'h16,
    FBC_OP_LZ         = 5'h17
  } fbc_op_t;
  typedef enum logic [1:0] {
    FBC_ST_FETCH = 2'b00,
    FBC_ST_EXEC2 = 2'b01
  } fbc_state_t;
endpackage

//--- fbc_stack.sv
// return-address stack, eight entries of program counter width
// assumes one write or one read per cycle; read data registered
`timescale 1ns/10ps
`include "fbc_params.svh"
module fbc_stack
  import fbc_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    wr_en,
  input  wire logic [`FBC_SP_W-1:0]    wr_addr,
  input  wire logic [`FBC_PC_W-1:0]    wr_data,
  input  wire logic [`FBC_SP_W-1:0]    rd_addr,
  output logic      [`FBC_PC_W-1:0]    rd_data
);
  logic [`FBC_PC_W-1:0] mem [`FBC_STK_DEPTH];
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

//--- fbc_sync.sv
// three-stage synchroniser with agreement of last two stages
// assumes an asynchronous level input
`timescale 1ns/10ps
`include "fbc_params.svh"
module fbc_sync
  import fbc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule

//--- fbc_partner.sv
// partner model: data RAM, table ROM and the three request flags
// assumes the bench sets flags and the core clears them with its pulses
`timescale 1ns/10ps
module fbc_partner
  import fbc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [9:0]  data_address_pointer,
  input  wire logic        mem_we,
  input  wire logic [3:0]  mem_wdata,
  input  wire logic [13:0] program_counter,
  input  wire logic [2:0]  set_flags,
  input  wire logic [2:0]  clear_flags,
  output logic      [3:0]  mem_rdata,
  output logic      [7:0]  rom_data,
  output logic      [2:0]  request_flags
);
  logic [3:0] mem [0:1023];
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 4'(i) ^ 4'(i >> 6);
    end
  end
  assign mem_rdata = mem[data_address_pointer];
  assign rom_data  = program_counter[7:0] ^ 8'h5A;
  always @(posedge mclk) begin
    if (mem_we) begin
      mem[data_address_pointer] <= mem_wdata;
    end
    if (reset) begin
      request_flags <= 3'h0;
    end else begin
      request_flags <= (request_flags & ~clear_flags) | set_flags;
    end
  end
endmodule

//--- fbc_core_bench.sv
// self-checking bench for the instruction core
// assumes fbc_partner answers RAM reads in the same cycle
`timescale 1ns/10ps
module fbc_core_bench
  import fbc_pkg::*;
;
  logic mclk = 0, reset = 1, instr_valid = 0, mode = 1, aux_port_pin = 1, interrupt_pin = 0, sel = 0;
  fbc_op_t instr_op = FBC_OP_NOP;
  logic [3:0] instr_imm = 4'h0, mem_rdata, acc, breg, mem_wdata, wd;
  logic [1:0] instr_bit = 2'h0, port_two_pins = 2'h0;
  logic [6:0] instr_page = 7'h00, instr_offset = 7'h00;
  logic [7:0] rom_data, timer_load_data, tdat, seen = 8'h00;
  logic [9:0] conversion_result = 10'h000, data_address_pointer;
  logic [2:0] irq_en = 3'h0, set_flags = 3'h0, request_flags, stack_pointer;
  logic [13:0] program_counter, p;
  logic mem_we, carry_flag, skip_pending, busy;
  wire  [7:0] pulses;
  int num_errors = 0, checks_done = 0;
  ////////////////////////////////////////////////////////////////////////
  fbc_core fbc_core_i (.mclk(mclk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_imm(instr_imm), .instr_bit(instr_bit), .instr_page(instr_page), .instr_offset(instr_offset),
    .rom_data(rom_data), .mem_rdata(mem_rdata), .conversion_result(conversion_result),
    .converter_mode_bit(mode), .aux_port_pin(aux_port_pin), .port_two_pins(port_two_pins),
    .interrupt_pin(interrupt_pin), .pin_level_select_bit(sel), .ext_irq_enable_bit(irq_en[2]),
    .first_timer_irq_enable_bit(irq_en[1]), .second_timer_irq_enable_bit(irq_en[0]),
    .external_request_flag(request_flags[2]), .first_timer_request_flag(request_flags[1]),
    .second_timer_request_flag(request_flags[0]), .program_counter(program_counter),
    .data_address_pointer(data_address_pointer), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc),
    .breg(breg), .carry_flag(carry_flag), .stack_pointer(stack_pointer), .skip_pending(skip_pending),
    .busy(busy), .clear_external_request(pulses[6]), .clear_first_timer_request(pulses[5]),
    .clear_second_timer_request(pulses[4]), .first_timer_reload_we(pulses[3]),
    .first_timer_count_we(pulses[2]), .second_timer_reload_we(pulses[1]),
    .second_timer_count_we(pulses[0]), .timer_load_data(timer_load_data));
  fbc_partner fbc_partner_i (.mclk(mclk), .reset(reset), .data_address_pointer(data_address_pointer),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .program_counter(program_counter), .set_flags(set_flags),
    .clear_flags(pulses[6:4]), .mem_rdata(mem_rdata), .rom_data(rom_data), .request_flags(request_flags));
  assign pulses[7] = mem_we;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    seen <= seen | pulses;
    if (|pulses[3:0]) tdat <= timer_load_data;
    if (mem_we) wd <= mem_wdata;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic issue(input fbc_op_t op, input logic [3:0] imm = 4'h0, input logic [1:0] bt = 2'h0,
                       input logic [6:0] pg = 7'h00, input logic [6:0] off = 7'h00);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    seen = 8'h00;
    instr_valid = 1;
    instr_op = op;
    instr_imm = imm;
    instr_bit = bt;
    instr_page = pg;
    instr_offset = off;
    @(negedge mclk);
  endtask
  task automatic idle(input int n = 1);
    instr_valid = 0;
    instr_op = FBC_OP_NOP;
    repeat (n) @(negedge mclk);
  endtask
  task automatic load_ab(input logic [3:0] b, input logic [3:0] a);
    mode = 1;
    conversion_result = {2'b00, b, a};
    issue(FBC_OP_RDADC);
    idle();
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_dp_amc();
    issue(FBC_OP_LZ, 4'h0, 2'h2);
    issue(FBC_OP_LXY, 4'h3, 2'h1);
    idle();
    chk("dp", 16'h0231, data_address_pointer);
    load_ab(4'h0, 4'hF);
    issue(FBC_OP_AMC);
    chk("amc1", 16'h0018, {carry_flag, acc});
    issue(FBC_OP_AMC);
    chk("amc2", 16'h0012, {carry_flag, acc});
    idle();
  endtask
  task automatic t_skip();
    fbc_op_t ops [3] = '{FBC_OP_RET, FBC_OP_RETSKIP, FBC_OP_TABCALL};
    load_ab(4'h0, 4'h7);
    issue(FBC_OP_SEA, 4'h7);
    chk("sea", 16'h0001, skip_pending);
    p = program_counter;
    issue(FBC_OP_RDAUX);
    chk("skipacc", 16'h0007, acc);
    chk("skippc", p + 14'h0001, program_counter);
    chk("skipbusy", 16'h0000, busy);
    issue(FBC_OP_SEA, 4'h6);
    chk("seane", 16'h0000, skip_pending);
    foreach (ops[i]) begin
      issue(FBC_OP_SEA, 4'h7);
      issue(ops[i]);
      chk("onecyc", 16'h0000, {busy, skip_pending});
      chk("skipsp", 16'h0007, stack_pointer);
    end
    issue(FBC_OP_SETBIT, 4'h0, 2'h1);
    idle();
    chk("setbit", 16'h080B, {seen, wd});
    issue(FBC_OP_SKIPCLR, 4'h0, 2'h2);
    chk("szb0", 16'h0001, skip_pending);
    issue(FBC_OP_NOP);
    issue(FBC_OP_SKIPCLR, 4'h0, 2'h3);
    chk("szb1", 16'h0000, skip_pending);
    idle();
  endtask
  task automatic t_stack();
    p = program_counter;
    issue(FBC_OP_CALL, 4'h0, 2'h0, 7'h2A, 7'h15);
    chk("callpc", 16'h1515, program_counter);
    chk("callsp", 16'h0000, stack_pointer);
    issue(FBC_OP_RET);
    chk("retbusy", 16'h0001, busy);
    idle(2);
    chk("retpc", p + 14'h0001, program_counter);
    chk("retsp", 16'h0007, stack_pointer);
    load_ab(4'h0, 4'h4);
    p = program_counter;
    issue(FBC_OP_TABCALL, 4'h0, 2'h0, 7'h05);
    chk("tabpc", 16'h0294, program_counter);
    idle();
    chk("tabdata", 16'h00CE, {breg, acc});
    chk("tabret", p + 14'h0001, program_counter);
    chk("tabsp", 16'h0007, stack_pointer);
    issue(FBC_OP_CALL, 4'h0, 2'h0, 7'h2A, 7'h15);
    issue(FBC_OP_RETSKIP);
    idle();
    chk("rtsskip", 16'h0001, skip_pending);
    p = program_counter;
    issue(FBC_OP_BRANCH, 4'h0, 2'h0, 7'h11, 7'h22);
    chk("skipbr", p + 14'h0001, program_counter);
    issue(FBC_OP_BRANCH, 4'h0, 2'h0, 7'h11, 7'h22);
    chk("br", 16'h08A2, program_counter);
    idle();
  endtask
  task automatic req(input fbc_op_t op, input int k, input logic en);
    irq_en = 3'h0;
    irq_en[k] = en;
    set_flags[k] = 1;
    @(negedge mclk);
    set_flags = 3'h0;
    @(negedge mclk);
    issue(op);
    idle();
    chk("reqskip", 16'(!en), skip_pending);
    chk("reqclr", 16'(!en), seen[4 + k]);
    chk("reqflag", 16'(en), request_flags[k]);
    issue(FBC_OP_NOP);
    idle();
  endtask
  task automatic t_pin_ports();
    for (int i = 0; i < 4; i++) begin
      interrupt_pin = i[1];
      sel = i[0];
      idle(6);
      issue(FBC_OP_TPIN);
      chk("pin", 16'(i[1] == i[0]), skip_pending);
      issue(FBC_OP_NOP);
      idle();
    end
    port_two_pins = 2'b10;
    idle(6);
    load_ab(4'hF, 4'hF);
    issue(FBC_OP_RDAUX);
    chk("aux", 16'h0001, acc);
    issue(FBC_OP_RDP2);
    chk("p2", 16'h0002, acc);
    mode = 0;
    conversion_result = 10'h2D6;
    issue(FBC_OP_RDADC);
    chk("adc", 16'h00B5, {breg, acc});
    idle();
  endtask
  task automatic t_timer();
    fbc_op_t ops [3] = '{FBC_OP_LT1PAIR, FBC_OP_LT2PAIR, FBC_OP_LT1RELOAD};
    logic [3:0] ex [3] = '{4'hC, 4'h3, 4'h8};
    foreach (ops[i]) begin
      load_ab(4'hC, 4'h3);
      chk("cmpmode", 16'h00C3, {breg, acc});
      issue(ops[i]);
      idle(2);
      chk("twe", 16'(ex[i]), seen[3:0]);
      chk("tdat", 16'h00C3, tdat);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(negedge mclk);
    reset = 0;
    chk("rstsp", 16'h0007, stack_pointer);
    chk("rstpc", 16'h0000, program_counter);
    t_dp_amc();
    t_skip();
    t_stack();
    req(FBC_OP_TEXT, 2, 0);
    req(FBC_OP_TEXT, 2, 1);
    req(FBC_OP_TT1, 1, 0);
    req(FBC_OP_TT1, 1, 1);
    req(FBC_OP_TT2, 0, 0);
    req(FBC_OP_TT2, 0, 1);
    t_pin_ports();
    t_timer();
    tally_and_finish();
  end
endmodule
